// file: design/crb_pkg.sv
// Purpose: shared constants and types of the core register set
// Assumes: 16-bit data on the register port, word index addressing
// Notes:   condition code bit positions are fixed here for every file
`default_nettype none
package crb_pkg;

  // ---------------------------------------------------------------
  // register port map (word index)
  // ---------------------------------------------------------------
  localparam logic [3:0] CRB_IDX_IP    = 4'h0;
  localparam logic [3:0] CRB_IDX_ACC   = 4'h1;
  localparam logic [3:0] CRB_IDX_TMP   = 4'h2;
  localparam logic [3:0] CRB_IDX_IX    = 4'h3;
  localparam logic [3:0] CRB_IDX_EP    = 4'h4;
  localparam logic [3:0] CRB_IDX_SP    = 4'h5;
  localparam logic [3:0] CRB_IDX_PSW   = 4'h6;
  localparam logic [3:0] CRB_IDX_ALU   = 4'h7;
  localparam logic [3:0] CRB_IDX_STAT  = 4'h8;

  // ---------------------------------------------------------------
  // condition code byte fields
  // ---------------------------------------------------------------
  localparam int CRB_CC_H   = 7;
  localparam int CRB_CC_I   = 6;
  localparam int CRB_CC_IL1 = 5;
  localparam int CRB_CC_IL0 = 4;
  localparam int CRB_CC_N   = 3;
  localparam int CRB_CC_Z   = 2;
  localparam int CRB_CC_V   = 1;
  localparam int CRB_CC_C   = 0;

  // ---------------------------------------------------------------
  // alu command fields
  // ---------------------------------------------------------------
  localparam int CRB_CMD_OP_LO   = 0;
  localparam int CRB_CMD_BYTE    = 2;
  localparam int CRB_CMD_CARRYIN = 3;

  localparam logic [1:0] CRB_OP_ADD = 2'h0;
  localparam logic [1:0] CRB_OP_SUB = 2'h1;
  localparam logic [1:0] CRB_OP_SHL = 2'h2;
  localparam logic [1:0] CRB_OP_SHR = 2'h3;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CRB_CCR_RESET  = 8'h30;
  localparam logic [7:0]  CRB_BANK_RESET = 8'h00;
  localparam logic [15:0] CRB_WORD_RESET = 16'h0000;
  localparam logic [1:0]  CRB_IL_NONE    = 2'h3;

  // ---------------------------------------------------------------
  // memory space layout
  // ---------------------------------------------------------------
  localparam logic [1:0] CRB_AREA_IO   = 2'h0;
  localparam logic [1:0] CRB_AREA_DATA = 2'h1;
  localparam logic [1:0] CRB_AREA_PROG = 2'h2;
  localparam int CRB_REGS_PER_BANK = 8;
  localparam int CRB_GPR_WIDTH     = 8;

  // ---------------------------------------------------------------
  // state of the register set
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ip;
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [7:0]  bank;
    logic [7:0]  condition_code_byte;
    logic [15:0] rdata;
  } crb_state_s;

endpackage
`default_nettype wire

// file: design/crb_alu_if.sv
// Purpose: operand and flag bundle between register set and flag unit
// Assumes: one clock, purely combinational flag unit
// Notes:   byteMode limits the operation to the low byte
`timescale 1ns/10ps
`default_nettype none
interface crb_alu_if;
  logic [1:0]  op;
  logic        byteMode;
  logic        carryIn;
  logic [15:0] opA;
  logic [15:0] opB;
  logic [15:0] result;
  logic        halfCarry;
  logic        negative;
  logic        zero;
  logic        overflow;
  logic        carry;

  modport regs (output op, byteMode, carryIn, opA, opB,
                input  result, halfCarry, negative, zero, overflow, carry);
  modport unit (input  op, byteMode, carryIn, opA, opB,
                output result, halfCarry, negative, zero, overflow, carry);
endinterface
`default_nettype wire

// file: design/crb_flag_unit.sv
// Purpose: arithmetic and shift result with condition flags
// Assumes: operands stable in the cycle of the command
// Notes:   upper byte passes through unchanged in byte mode
`timescale 1ns/10ps
`default_nettype none
module crb_flag_unit
  import crb_pkg::*;
(
  crb_alu_if.unit alu
);

  logic [4:0]  nib;
  logic [8:0]  low9;
  logic [16:0] full17;
  logic [15:0] res;
  logic        msbA;
  logic        msbB;
  logic        msbR;

  always_comb begin
    nib    = 5'h00;
    low9   = 9'h000;
    full17 = 17'h00000;
    res    = alu.opA;
    alu.halfCarry = 1'b0;
    alu.overflow  = 1'b0;
    alu.carry     = 1'b0;
    msbA = alu.byteMode ? alu.opA[7] : alu.opA[15];
    msbB = alu.byteMode ? alu.opB[7] : alu.opB[15];
    case (alu.op)
      CRB_OP_ADD: begin
        nib    = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, alu.carryIn};
        low9   = {1'b0, alu.opA[7:0]} + {1'b0, alu.opB[7:0]} + {8'h00, alu.carryIn};
        full17 = {1'b0, alu.opA} + {1'b0, alu.opB} + {16'h0000, alu.carryIn};
      end
      CRB_OP_SUB: begin
        nib    = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, alu.carryIn};
        low9   = {1'b0, alu.opA[7:0]} - {1'b0, alu.opB[7:0]} - {8'h00, alu.carryIn};
        full17 = {1'b0, alu.opA} - {1'b0, alu.opB} - {16'h0000, alu.carryIn};
      end
      default: ;
    endcase
    case (alu.op)
      CRB_OP_ADD, CRB_OP_SUB: begin
        res = alu.byteMode ? {alu.opA[15:8], low9[7:0]} : full17[15:0];
        alu.halfCarry = nib[4];
        alu.carry     = alu.byteMode ? low9[8] : full17[16];
      end
      CRB_OP_SHL: begin
        res = alu.byteMode ? {alu.opA[15:8], alu.opA[6:0], alu.carryIn}
                           : {alu.opA[14:0], alu.carryIn};
        alu.carry = msbA;
      end
      CRB_OP_SHR: begin
        res = alu.byteMode ? {alu.opA[15:8], alu.carryIn, alu.opA[7:1]}
                           : {alu.carryIn, alu.opA[15:1]};
        alu.carry = alu.opA[0];
      end
      default: ;
    endcase
    msbR = alu.byteMode ? res[7] : res[15];
    if (alu.op == CRB_OP_ADD) begin
      alu.overflow = (msbA == msbB) && (msbR != msbA);
    end else if (alu.op == CRB_OP_SUB) begin
      alu.overflow = (msbA != msbB) && (msbR != msbA);
    end
    alu.negative = msbR;
    alu.zero     = alu.byteMode ? (res[7:0] == 8'h00) : (res == 16'h0000);
    alu.result   = res;
  end

endmodule
`default_nettype wire

// file: design/crb_core_regs.sv
// Purpose: dedicated register set, status word and bank selection of the core
// Assumes: register port strobes from logic on clk, one cycle each
// Notes:   general-purpose registers live in data memory, not here
`timescale 1ns/10ps
`default_nettype none
module crb_core_regs
  import crb_pkg::*;
#(
  parameter int          NUM_BANKS = 32,
  parameter logic [15:0] IP_RESET  = 16'h0000,
  parameter logic [15:0] IO_END    = 16'h0080,
  parameter logic [15:0] PROG_BASE = 16'h8000
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  input  wire logic        fetchStep,
  output logic      [15:0] fetchAddr,
  input  wire logic [7:0]  indexOffset,
  output logic      [15:0] indexedAddr,
  output logic      [15:0] extraAddr,
  output logic      [15:0] stackAddr,
  input  wire logic [2:0]  gprIndex,
  output logic      [7:0]  gprNumber,
  input  wire logic        irqRequest,
  input  wire logic [1:0]  irqLevel,
  output logic             irqAccept,
  input  wire logic [15:0] memAddr,
  output logic      [1:0]  memArea
);

  // ---------------------------------------------------------------
  // constants and state
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK_MASK = 8'(NUM_BANKS - 1);

  crb_state_s st;
  crb_state_s next_st;
  crb_alu_if  alu ();

  logic        aluGo;
  logic [7:0]  bankActive;
  logic [7:0]  nextCcr;
  logic [15:0] readMux;

  // ---------------------------------------------------------------
  // flag unit
  // ---------------------------------------------------------------
  crb_flag_unit u_flags (
    .alu (alu.unit)
  );

  assign aluGo        = regWr && (regAddr == CRB_IDX_ALU);
  assign alu.op       = regWdata[CRB_CMD_OP_LO +: 2];
  assign alu.byteMode = regWdata[CRB_CMD_BYTE];
  assign alu.carryIn  = regWdata[CRB_CMD_CARRYIN] & st.condition_code_byte[CRB_CC_C];
  assign alu.opA      = st.acc;
  assign alu.opB      = st.tmp;

  always_comb begin
    nextCcr = st.condition_code_byte;
    nextCcr[CRB_CC_N] = alu.negative;
    nextCcr[CRB_CC_Z] = alu.zero;
    nextCcr[CRB_CC_C] = alu.carry;
    nextCcr[CRB_CC_V] = alu.overflow;
    if (alu.op == CRB_OP_ADD || alu.op == CRB_OP_SUB) begin
      nextCcr[CRB_CC_H] = alu.halfCarry;
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rdata = 16'h0000;
    if (fetchStep) begin
      next_st.ip = st.ip + 16'h0001;
    end
    if (aluGo) begin
      next_st.acc = alu.result;
      next_st.condition_code_byte = nextCcr;
    end
    if (regWr) begin
      case (regAddr)
        CRB_IDX_IP:  next_st.ip  = regWdata;
        CRB_IDX_ACC: next_st.acc = regWdata;
        CRB_IDX_TMP: next_st.tmp = regWdata;
        CRB_IDX_IX:  next_st.ix  = regWdata;
        CRB_IDX_EP:  next_st.ep  = regWdata;
        CRB_IDX_SP:  next_st.sp  = regWdata;
        CRB_IDX_PSW: begin
          next_st.bank = regWdata[15:8];
          next_st.condition_code_byte  = regWdata[7:0];
        end
        default: ;
      endcase
    end
    if (regRd) begin
      next_st.rdata = readMux;
    end
  end

  // ---------------------------------------------------------------
  // read selection
  // ---------------------------------------------------------------
  always_comb begin
    case (regAddr)
      CRB_IDX_IP:   readMux = st.ip;
      CRB_IDX_ACC:  readMux = st.acc;
      CRB_IDX_TMP:  readMux = st.tmp;
      CRB_IDX_IX:   readMux = st.ix;
      CRB_IDX_EP:   readMux = st.ep;
      CRB_IDX_SP:   readMux = st.sp;
      CRB_IDX_PSW:  readMux = {st.bank, st.condition_code_byte};
      CRB_IDX_STAT: readMux = {7'h00, irqAccept, gprNumber};
      default:      readMux = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.ip    <= IP_RESET;
      st.acc   <= CRB_WORD_RESET;
      st.tmp   <= CRB_WORD_RESET;
      st.ix    <= CRB_WORD_RESET;
      st.ep    <= CRB_WORD_RESET;
      st.sp    <= CRB_WORD_RESET;
      st.bank  <= CRB_BANK_RESET;
      st.condition_code_byte   <= CRB_CCR_RESET;
      st.rdata <= CRB_WORD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign regRdata    = st.rdata;
  assign fetchAddr   = st.ip;
  assign indexedAddr = st.ix + {8'h00, indexOffset};
  assign extraAddr   = st.ep;
  assign stackAddr   = st.sp;

  // bank pointer limited to the banks that RAM provides
  assign bankActive  = st.bank & BANK_MASK;
  assign gprNumber   = {bankActive[4:0], gprIndex};

  // interrupt admission: enable and strict priority against the mask
  assign irqAccept = irqRequest && st.condition_code_byte[CRB_CC_I]
                     && (irqLevel < st.condition_code_byte[CRB_CC_IL1:CRB_CC_IL0]);

  // memory space decode over the 64-Kbyte space
  always_comb begin
    if (memAddr < IO_END) begin
      memArea = CRB_AREA_IO;
    end else if (memAddr < PROG_BASE) begin
      memArea = CRB_AREA_DATA;
    end else begin
      memArea = CRB_AREA_PROG;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_irq_needs_enable;
    @(posedge clk) disable iff (!rstn)
    irqAccept |-> st.condition_code_byte[CRB_CC_I] && irqLevel != CRB_IL_NONE;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable)
    else $error("interrupt accepted while disabled");

  property p_irq_mask3_blocks;
    @(posedge clk) disable iff (!rstn)
    (st.condition_code_byte[CRB_CC_IL1:CRB_CC_IL0] == CRB_IL_NONE && irqLevel == CRB_IL_NONE) |-> !irqAccept;
  endproperty
  a_irq_mask3_blocks: assert property (p_irq_mask3_blocks)
    else $error("mask value three admitted a request");

  property p_irq_accept_level;
    @(posedge clk) disable iff (!rstn)
    (irqRequest && st.condition_code_byte[CRB_CC_I] && irqLevel < st.condition_code_byte[CRB_CC_IL1:CRB_CC_IL0]) |-> irqAccept;
  endproperty
  a_irq_accept_level: assert property (p_irq_accept_level)
    else $error("valid request refused");

  property p_psw_write;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == CRB_IDX_PSW) |=> (st.bank == $past(regWdata[15:8]))
                                          && (st.condition_code_byte == $past(regWdata[7:0]));
  endproperty
  a_psw_write: assert property (p_psw_write)
    else $error("status word write not split into bank and codes");

  property p_byte_keeps_high;
    @(posedge clk) disable iff (!rstn)
    (aluGo && regWdata[CRB_CMD_BYTE]) |=> st.acc[15:8] == $past(st.acc[15:8]);
  endproperty
  a_byte_keeps_high: assert property (p_byte_keeps_high)
    else $error("byte operation changed accumulator high byte");

  property p_zero_flag;
    @(posedge clk) disable iff (!rstn)
    (aluGo && regWdata[CRB_CMD_BYTE]) |=> st.condition_code_byte[CRB_CC_Z] == (st.acc[7:0] == 8'h00);
  endproperty
  a_zero_flag: assert property (p_zero_flag)
    else $error("zero flag disagrees with result");

  property p_neg_flag;
    @(posedge clk) disable iff (!rstn)
    (aluGo && !regWdata[CRB_CMD_BYTE]) |=> st.condition_code_byte[CRB_CC_N] == st.acc[15];
  endproperty
  a_neg_flag: assert property (p_neg_flag)
    else $error("negative flag disagrees with result");

  property p_shr_carry;
    @(posedge clk) disable iff (!rstn)
    (aluGo && regWdata[CRB_CMD_OP_LO +: 2] == CRB_OP_SHR) |=> st.condition_code_byte[CRB_CC_C] == $past(st.acc[0]);
  endproperty
  a_shr_carry: assert property (p_shr_carry)
    else $error("shift carry not the bit shifted out");

  property p_fetch_step;
    @(posedge clk) disable iff (!rstn)
    (fetchStep && !(regWr && regAddr == CRB_IDX_IP)) |=> fetchAddr == $past(fetchAddr) + 16'h0001;
  endproperty
  a_fetch_step: assert property (p_fetch_step)
    else $error("instruction pointer did not advance");

  property p_bank_select;
    @(posedge clk) disable iff (!rstn)
    gprNumber == {5'((st.bank & BANK_MASK)), gprIndex};
  endproperty
  a_bank_select: assert property (p_bank_select)
    else $error("register number not from active bank");

  property p_io_lowest;
    @(posedge clk) disable iff (!rstn)
    (memAddr == 16'h0000) |-> memArea == CRB_AREA_IO;
  endproperty
  a_io_lowest: assert property (p_io_lowest)
    else $error("lowest address not in I/O area");

  property p_read_one_cycle;
    @(posedge clk) disable iff (!rstn)
    !regRd |=> regRdata == 16'h0000;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle)
    else $error("read data outside its cycle");

  property p_reset_irq_off;
    @(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> !st.condition_code_byte[CRB_CC_I] && !irqAccept;
  endproperty
  a_reset_irq_off: assert property (p_reset_irq_off)
    else $error("interrupt enable not cleared by reset");

  property p_add_carry;
    @(posedge clk) disable iff (!rstn)
    (aluGo && alu.op == CRB_OP_ADD && alu.byteMode && !regWdata[CRB_CMD_CARRYIN])
      |=> st.condition_code_byte[CRB_CC_C] == (st.acc[7:0] < $past(st.acc[7:0]));
  endproperty
  a_add_carry: assert property (p_add_carry)
    else $error("carry flag wrong after byte addition");

  property p_sub_borrow;
    @(posedge clk) disable iff (!rstn)
    (aluGo && alu.op == CRB_OP_SUB && alu.byteMode && !regWdata[CRB_CMD_CARRYIN])
      |=> st.condition_code_byte[CRB_CC_C] == ($past(st.acc[7:0]) < $past(st.tmp[7:0]));
  endproperty
  a_sub_borrow: assert property (p_sub_borrow)
    else $error("borrow flag wrong after byte subtraction");

  property p_half_carry;
    @(posedge clk) disable iff (!rstn)
    (aluGo && alu.op == CRB_OP_ADD && !regWdata[CRB_CMD_CARRYIN])
      |=> st.condition_code_byte[CRB_CC_H] == (st.acc[3:0] < $past(st.acc[3:0]));
  endproperty
  a_half_carry: assert property (p_half_carry)
    else $error("half carry flag wrong after addition");

  property p_shl_carry;
    @(posedge clk) disable iff (!rstn)
    (aluGo && alu.op == CRB_OP_SHL)
      |=> st.condition_code_byte[CRB_CC_C] == ($past(alu.byteMode) ? $past(st.acc[7]) : $past(st.acc[15]));
  endproperty
  a_shl_carry: assert property (p_shl_carry)
    else $error("left shift carry not the bit shifted out");

  property p_shift_no_overflow;
    @(posedge clk) disable iff (!rstn)
    (aluGo && (alu.op == CRB_OP_SHL || alu.op == CRB_OP_SHR)) |=> !st.condition_code_byte[CRB_CC_V];
  endproperty
  a_shift_no_overflow: assert property (p_shift_no_overflow)
    else $error("overflow flag set by a shift");

  property p_add_overflow;
    @(posedge clk) disable iff (!rstn)
    (aluGo && alu.op == CRB_OP_ADD && alu.byteMode && !regWdata[CRB_CMD_CARRYIN])
      |=> st.condition_code_byte[CRB_CC_V] == (($past(st.acc[7]) == $past(st.tmp[7])) && (st.acc[7] != $past(st.acc[7])));
  endproperty
  a_add_overflow: assert property (p_add_overflow)
    else $error("overflow flag wrong after byte addition");

  property p_sp_write;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == CRB_IDX_SP) |=> stackAddr == $past(regWdata);
  endproperty
  a_sp_write: assert property (p_sp_write)
    else $error("stack pointer write not taken");

  property p_ep_write;
    @(posedge clk) disable iff (!rstn)
    (regWr && regAddr == CRB_IDX_EP) |=> extraAddr == $past(regWdata);
  endproperty
  a_ep_write: assert property (p_ep_write)
    else $error("extra pointer write not taken");

  property p_area_top;
    @(posedge clk) disable iff (!rstn)
    (memAddr >= PROG_BASE) |-> memArea == CRB_AREA_PROG;
  endproperty
  a_area_top: assert property (p_area_top)
    else $error("top of space not in program area");

endmodule
`default_nettype wire

// file: testbench/crb_core_regs_bench.sv
// Purpose: self-checking bench of the core register set
// Assumes: design defaults, word index register port, fixed seed
// Notes:   random stimulus with hand-picked corner cases
`timescale 1ns/10ps
`default_nettype none
module crb_core_regs_bench
  import crb_pkg::*;
();
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [15:0] IO_END    = 16'h0080;
  localparam logic [15:0] PROG_BASE = 16'h8000;
  logic        clk;
  logic        rstn;
  logic [3:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic        fetchStep;
  logic [15:0] fetchAddr;
  logic [7:0]  indexOffset;
  logic [15:0] indexedAddr;
  logic [15:0] extraAddr;
  logic [15:0] stackAddr;
  logic [2:0]  gprIndex;
  logic [7:0]  gprNumber;
  logic        irqRequest;
  logic [1:0]  irqLevel;
  logic        irqAccept;
  logic [15:0] memAddr;
  logic [1:0]  memArea;
  int          fails, nCompared, cycles;
  logic [15:0] val [6];
  logic [15:0] a, b, p;
  logic [23:0] e;
  logic [3:0]  cmd;
  logic [15:0] areas [6] = '{16'h0000, 16'h007F, 16'h0080, 16'h7FFF, 16'h8000, 16'hFFFF};

  crb_core_regs #(.NUM_BANKS(32), .IP_RESET(16'h0000), .IO_END(IO_END), .PROG_BASE(PROG_BASE)) i_crb_core_regs (
    .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .fetchStep(fetchStep), .fetchAddr(fetchAddr), .indexOffset(indexOffset),
    .indexedAddr(indexedAddr), .extraAddr(extraAddr), .stackAddr(stackAddr), .gprIndex(gprIndex),
    .gprNumber(gprNumber), .irqRequest(irqRequest), .irqLevel(irqLevel), .irqAccept(irqAccept),
    .memAddr(memAddr), .memArea(memArea));

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge clk);
    regAddr  <= ad;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand one cycle, then return to zero
  task automatic rd(input logic [3:0] ad, input logic [15:0] exp);
    @(posedge clk);
    regAddr <= ad;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, exp);
    @(posedge clk);
    #1;
    chk(regRdata, 16'h0000);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // expected {accumulator, condition codes} after one alu command
  function automatic logic [23:0] alu_exp(input logic [3:0] c, input logic [15:0] x, input logic [15:0] y,
                                          input logic [7:0] cc);
    logic [16:0] s;
    logic [4:0]  h;
    logic [15:0] xa, ya;
    logic        ci, co, hf, v;
    int          w;
    ci = c[3] & cc[0];
    w  = c[2] ? 8 : 16;
    xa = c[2] ? {8'h00, x[7:0]} : x;
    ya = c[2] ? {8'h00, y[7:0]} : y;
    hf = cc[7];
    v  = 1'b0;
    case (c[1:0])
      2'h0: begin
        s  = {1'b0, xa} + {1'b0, ya} + {16'h0000, ci};
        h  = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
        hf = h[4];
        co = s[w];
        v  = (xa[w-1] == ya[w-1]) && (s[w-1] != xa[w-1]);
      end
      2'h1: begin
        s  = {1'b0, xa} - {1'b0, ya} - {16'h0000, ci};
        h  = {1'b0, x[3:0]} - {1'b0, y[3:0]} - {4'h0, ci};
        hf = h[4];
        co = s[w];
        v  = (xa[w-1] != ya[w-1]) && (s[w-1] != xa[w-1]);
      end
      2'h2: begin
        s  = {xa, ci};
        co = xa[w-1];
      end
      default: begin
        s = {1'b0, xa >> 1};
        s[w-1] = ci;
        co = xa[0];
      end
    endcase
    if (c[2]) begin
      return {x[15:8], s[7:0], hf, cc[6:4], s[7], s[7:0] == 8'h00, v, co};
    end
    return {s[15:0], hf, cc[6:4], s[15], s[15:0] == 16'h0000, v, co};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rstn, regAddr, regWdata, regWr, regRd, fetchStep, indexOffset} = '0;
    {gprIndex, irqRequest, irqLevel, memAddr} = '0;
    fails = 0;
    nCompared = 0;
    cycles = 0;
    void'($urandom(92753));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(fetchAddr, 16'h0000);
    chk({15'h0000, irqAccept}, 16'h0000);
    rd(CRB_IDX_PSW, 16'h0030);
    for (int i = 0; i < 6; i++) begin
      val[i] = 16'($urandom);
      wr(4'(i), val[i]);
      rd(4'(i), val[i]);
    end
    chk(fetchAddr, val[0]);
    chk(extraAddr, val[4]);
    chk(stackAddr, val[5]);
    @(posedge clk);
    fetchStep   <= 1'b1;
    indexOffset <= 8'($urandom);
    @(posedge clk);
    fetchStep <= 1'b0;
    #1;
    chk(fetchAddr, val[0] + 16'h0001);
    chk(indexedAddr, val[3] + {8'h00, indexOffset});
    wr(4'hF, 16'hA5A5);
    rd(4'hF, 16'h0000);
    for (int k = 0; k < 64; k++) begin
      p = {8'($urandom), 1'b0, k[5], k[4:3], 4'h0};
      wr(CRB_IDX_PSW, p);
      irqRequest <= k[0];
      irqLevel   <= k[2:1];
      gprIndex   <= 3'($urandom);
      #1;
      chk({15'h0000, irqAccept}, {15'h0000, k[0] & k[5] & (k[2:1] < k[4:3])});
      chk({8'h00, gprNumber}, {8'h00, p[12:8], gprIndex});
      rd(CRB_IDX_STAT, {7'h00, k[0] & k[5] & (k[2:1] < k[4:3]), p[12:8], gprIndex});
    end
    rd(CRB_IDX_PSW, p);
    for (int i = 0; i < 48; i++) begin
      a   = (i < 4) ? 16'h0F7F : 16'($urandom);
      b   = (i < 4) ? 16'h0001 : 16'($urandom);
      p   = 16'($urandom);
      cmd = {2'($urandom), 2'(i)};
      wr(CRB_IDX_ACC, a);
      wr(CRB_IDX_TMP, b);
      wr(CRB_IDX_PSW, p);
      wr(CRB_IDX_ALU, {12'h000, cmd});
      e = alu_exp(cmd, a, b, p[7:0]);
      rd(CRB_IDX_ACC, e[23:8]);
      rd(CRB_IDX_PSW, {p[15:8], e[7:0]});
    end
    wr(CRB_IDX_PSW, 16'hFF7F);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(CRB_IDX_PSW, 16'h0030);
    chk(fetchAddr, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      memAddr <= areas[i];
      #1;
      chk({14'h0000, memArea}, (areas[i] < IO_END) ? 16'h0000 : (areas[i] < PROG_BASE) ? 16'h0001 : 16'h0002);
    end
    end_of_test();
  end
endmodule
`default_nettype wire
